// ==== hdl/smid_consts.vh ====
// Purpose: constants of the system module and interrupt decode block
// Assumes: one clock, synchronous reset
// Notes:   address fields are bus byte addresses
`ifndef SMID_CONSTS_VH
`define SMID_CONSTS_VH
`define SMID_NCHAN          32
`define SMID_CH_BROWNOUT    5'h00
`define SMID_CH_EXTPIN      5'h01
`define SMID_CH_WD_EXPIRY   5'h02
`define SMID_CH_WD_HALF     5'h03
`define SMID_CH_SER_ERR     5'h04
`define SMID_CH_SER0_RX     5'h05
`define SMID_CH_SER0_TX     5'h06
`define SMID_CH_SER1_RX     5'h07
`define SMID_CH_SER1_TX     5'h08
`define SMID_CH_PMBUS       5'h09
`define SMID_CH_CMP_SER     5'h0A
`define SMID_CH_FE0         5'h0B
`define SMID_CH_SOFT        5'h1F
`define SMID_CFG_BASE       32'hFFFF_FD00
`define SMID_CFG_MASK_LO    32'h0000_0000
`define SMID_CFG_MASK_HI    32'h0000_0004
`define SMID_CFG_LEVEL      32'h0000_0008
`define SMID_CFG_SOFT       32'h0000_000C
`define SMID_CFG_FASTVEC    32'h0000_0010
`define SMID_CFG_NORMVEC    32'h0000_0014
`define SMID_CFG_PENDING    32'h0000_0018
`define SMID_CFG_SEL_BASE   32'h0000_0020
`define SMID_CFG_SEL_SIZE   32'h0000_0030
`define SMID_CFG_PRIV       32'h0000_0040
`define SMID_CFG_FAULTMODE  32'h0000_0044
`define SMID_CFG_SPAN       32'h0000_0100
`define SMID_ROM_BASE_RST   32'h0000_0000
`define SMID_FLASH_BASE_RST 32'h0001_0000
`define SMID_RAM_BASE_RST   32'h0006_0000
`define SMID_SIZE_RST       5'h0F
`define SMID_SIZE_MIN       5'h0A
`define SMID_SIZE_MAX       5'h18
`define SMID_PERIPH_BASE    32'hFFF7_0000
`define SMID_PERIPH_SHIFT   10
`define SMID_MASK_RST       32'h0000_0000
`define SMID_PRIV_RST       11'h000
`define SMID_CFG_WAIT       2'h1
`endif

// ==== hdl/smid_top.v ====
// Purpose: system module of a power controller: memory selects, peripheral
//          selects with stretching, access protection, interrupt unit
// Assumes: single-beat bus, one access per request pulse, I_CLK 100 MHz
// Notes:   interrupt unit flags are held by the sources; masks only hide
//
// Summary of operation
// - Thirty-one interrupt request inputs plus the software channel enter the interrupt unit.
// - Fast and normal interrupt outputs; each driven on its own, both can be active at once.
// - Each level has a readable vector giving highest pending channel index.
// - Fixed precedence: higher channel number wins, channel 31 highest.
// - Each channel has a mask bit; masked channels raise no interrupt.
// - Channel 0 is brownout, channel 1 external pin.
// - Channel 2 watchdog expiry, channel 3 watchdog half-time wake.
// - Channel 4 combined serial framing, parity, overrun error.
// - Channels 5,6 serial port 0 rx/tx; channels 7,8 port 1.
// - Channel 9 power-management bus; channel 10 comparator/SPI/I2C.
// - Channel 11 carries the first front-end event group.
// - Flash, ROM, RAM selects with programmable base and 1 kB-16 MB size.
// - Reset map places boot ROM at the execution start address.
// - Accesses to the block's own registers answer as fast as memory accesses, with no added wait state.
// - Register writes take effect only in privileged mode.
// - Eight peripheral selects, each a 1 kB window.
// - Peripheral accesses stretched until the peripheral reports ready.
// - Per-region privilege check raises fault or reset as configured.
// - Channel 31 is a software-raised system interrupt.
`timescale 1ns/1ns
`include "smid_consts.vh"
module smid_top (
  // clock and reset
  input  wire        I_CLK,
  input  wire        I_NRST,
  // processor bus
  input  wire        I_REQ,
  input  wire        I_WRITE,
  input  wire        I_PRIV,
  input  wire [31:0] I_ADDR,
  input  wire [31:0] I_WDATA,
  output reg  [31:0] O_RDATA,
  output reg         O_DONE,
  // memory and peripheral selects
  output reg         O_ROM_SEL,
  output reg         O_FLASH_SEL,
  output reg         O_RAM_SEL,
  output reg  [7:0]  O_PERIPH_SEL,
  input  wire        I_PERIPH_READY,
  input  wire [31:0] I_PERIPH_RDATA,
  input  wire [31:0] I_MEM_RDATA,
  // protection results
  output reg         O_FAULT,
  output reg         O_SYS_RESET,
  // interrupt sources
  input  wire        I_BROWNOUT_REQUEST,
  input  wire        I_EXTERNAL_PIN_REQUEST,
  input  wire        I_WATCHDOG_EXPIRY_REQUEST,
  input  wire        I_WATCHDOG_HALF_REQUEST,
  input  wire        I_SERIAL_ERROR_REQUEST,
  input  wire        I_SERIAL0_RECEIVE_REQUEST,
  input  wire        I_SERIAL0_TRANSMIT_REQUEST,
  input  wire        I_SERIAL1_RECEIVE_REQUEST,
  input  wire        I_SERIAL1_TRANSMIT_REQUEST,
  input  wire        I_PMBUS_REQUEST,
  input  wire        I_COMPARATOR_SERIAL_REQUEST,
  input  wire        I_FRONT_END_ZERO_REQUEST,
  input  wire [18:0] I_UPPER_REQUEST,
  // processor interrupt levels
  output reg         O_FAST_INTERRUPT_LEVEL,
  output reg         O_NORMAL_INTERRUPT_LEVEL
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_WAIT  = 2'h1;
  localparam ST_PERIF = 2'h2;
  localparam ST_MEM   = 2'h3;

  // highest set bit index, 6'h20 flags "none"
  function [5:0] top_index;
    input [31:0] v;
    integer k;
    begin
      top_index = 6'h20;
      for (k = 0; k < `SMID_NCHAN; k = k + 1) begin
        if (v[k]) begin
          top_index = k[5:0];
        end
      end
    end
  endfunction

  // address within a window given base and log2 size
  function in_window;
    input [31:0] a;
    input [31:0] base;
    input [4:0]  lg;
    reg   [31:0] m;
    begin
      m = 32'hFFFF_FFFF << lg;
      in_window = ((a & m) == (base & m));
    end
  endfunction

  // limit a programmed size to the legal range
  function [4:0] clamp_size;
    input [4:0] s;
    begin
      if (s < `SMID_SIZE_MIN) begin
        clamp_size = `SMID_SIZE_MIN;
      end else if (s > `SMID_SIZE_MAX) begin
        clamp_size = `SMID_SIZE_MAX;
      end else begin
        clamp_size = s;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  reg  [1:0]  state_reg;
  reg  [1:0]  wait_cnt_reg;
  reg  [31:0] mask_reg;        // 1 = channel enabled
  reg  [31:0] level_reg;       // 1 = fast level
  reg         soft_reg;
  reg  [31:0] rom_base_reg;
  reg  [31:0] flash_base_reg;
  reg  [31:0] ram_base_reg;
  reg  [4:0]  rom_size_reg;
  reg  [4:0]  flash_size_reg;
  reg  [4:0]  ram_size_reg;
  reg  [10:0] priv_reg;        // 1 = region needs privilege
  reg         fault_mode_reg;  // 0 fault, 1 reset
  reg         write_reg;
  reg  [31:0] addr_reg;

  ////////////////////////////////////////////////////////////////////////
  // interrupt unit
  wire [31:0] raw_req;
  wire [31:0] live_req;
  wire [31:0] fast_req;
  wire [31:0] norm_req;
  wire [5:0]  fast_idx;
  wire [5:0]  norm_idx;

  // fixed channel assignment of the sources
  assign raw_req[`SMID_CH_BROWNOUT]   = I_BROWNOUT_REQUEST;
  assign raw_req[`SMID_CH_EXTPIN]     = I_EXTERNAL_PIN_REQUEST;
  assign raw_req[`SMID_CH_WD_EXPIRY]  = I_WATCHDOG_EXPIRY_REQUEST;
  assign raw_req[`SMID_CH_WD_HALF]    = I_WATCHDOG_HALF_REQUEST;
  assign raw_req[`SMID_CH_SER_ERR]    = I_SERIAL_ERROR_REQUEST;
  assign raw_req[`SMID_CH_SER0_RX]    = I_SERIAL0_RECEIVE_REQUEST;
  assign raw_req[`SMID_CH_SER0_TX]    = I_SERIAL0_TRANSMIT_REQUEST;
  assign raw_req[`SMID_CH_SER1_RX]    = I_SERIAL1_RECEIVE_REQUEST;
  assign raw_req[`SMID_CH_SER1_TX]    = I_SERIAL1_TRANSMIT_REQUEST;
  assign raw_req[`SMID_CH_PMBUS]      = I_PMBUS_REQUEST;
  assign raw_req[`SMID_CH_CMP_SER]    = I_COMPARATOR_SERIAL_REQUEST;
  assign raw_req[`SMID_CH_FE0]        = I_FRONT_END_ZERO_REQUEST;
  // upper channels 12..30 plus the software channel
  assign raw_req[30:12] = I_UPPER_REQUEST;
  assign raw_req[`SMID_CH_SOFT] = soft_reg;

  // level requests from the source: masking gates, never clears
  assign live_req = raw_req & mask_reg;
  assign fast_req = live_req & level_reg;
  assign norm_req = live_req & ~level_reg;
  assign fast_idx = top_index(fast_req);
  assign norm_idx = top_index(norm_req);

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire        hit_cfg;
  wire        hit_periph;
  wire        hit_rom;
  wire        hit_flash;
  wire        hit_ram;
  wire [3:0]  region;
  wire        illegal;
  wire [31:0] cfg_off;
  wire [31:0] periph_off;

  assign cfg_off    = I_ADDR - `SMID_CFG_BASE;
  assign periph_off = I_ADDR - `SMID_PERIPH_BASE;
  assign hit_cfg    = (I_ADDR >= `SMID_CFG_BASE) &&
                      (cfg_off < `SMID_CFG_SPAN);
  assign hit_periph = (I_ADDR >= `SMID_PERIPH_BASE) &&
                      (periph_off[31:`SMID_PERIPH_SHIFT] < 22'h8);
  assign hit_rom   = in_window(I_ADDR, rom_base_reg, rom_size_reg);
  assign hit_flash = in_window(I_ADDR, flash_base_reg, flash_size_reg);
  assign hit_ram   = in_window(I_ADDR, ram_base_reg, ram_size_reg);
  // protection regions: 0 rom, 1 flash, 2 ram, 3..10 peripherals
  assign region = hit_rom    ? 4'h0 :
                  hit_flash  ? 4'h1 :
                  hit_ram    ? 4'h2 :
                  hit_periph ? (4'h3 + {1'b0, periph_off[12:10]}) : 4'hF;
  // unmapped address or unprivileged access to a guarded region
  assign illegal = !hit_cfg && ((region == 4'hF) ||
                   (!I_PRIV && priv_reg[region]));

  ////////////////////////////////////////////////////////////////////////
  // register read mux
  reg [31:0] cfg_rdata;
  always @* begin
    cfg_rdata = 32'h0000_0000;
    if (addr_reg[7:0] == `SMID_CFG_MASK_LO) begin
      cfg_rdata = mask_reg;
    end else if (addr_reg[7:0] == `SMID_CFG_LEVEL) begin
      cfg_rdata = level_reg;
    end else if (addr_reg[7:0] == `SMID_CFG_SOFT) begin
      cfg_rdata = {31'h0, soft_reg};
    end else if (addr_reg[7:0] == `SMID_CFG_FASTVEC) begin
      cfg_rdata = {26'h0, fast_idx};
    end else if (addr_reg[7:0] == `SMID_CFG_NORMVEC) begin
      cfg_rdata = {26'h0, norm_idx};
    end else if (addr_reg[7:0] == `SMID_CFG_PENDING) begin
      cfg_rdata = raw_req;
    end else if (addr_reg[7:0] == `SMID_CFG_SEL_BASE) begin
      cfg_rdata = rom_base_reg;
    end else if (addr_reg[7:0] == `SMID_CFG_SEL_BASE + 32'h4) begin
      cfg_rdata = flash_base_reg;
    end else if (addr_reg[7:0] == `SMID_CFG_SEL_BASE + 32'h8) begin
      cfg_rdata = ram_base_reg;
    end else if (addr_reg[7:0] == `SMID_CFG_SEL_SIZE) begin
      cfg_rdata = {27'h0, rom_size_reg};
    end else if (addr_reg[7:0] == `SMID_CFG_SEL_SIZE + 32'h4) begin
      cfg_rdata = {27'h0, flash_size_reg};
    end else if (addr_reg[7:0] == `SMID_CFG_SEL_SIZE + 32'h8) begin
      cfg_rdata = {27'h0, ram_size_reg};
    end else if (addr_reg[7:0] == `SMID_CFG_PRIV) begin
      cfg_rdata = {21'h0, priv_reg};
    end else if (addr_reg[7:0] == `SMID_CFG_FAULTMODE) begin
      cfg_rdata = {31'h0, fault_mode_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus sequencer, selects, protection and configuration writes
  always @(posedge I_CLK) begin
    if (!I_NRST) begin
      state_reg      <= ST_IDLE;
      wait_cnt_reg   <= 2'h0;
      mask_reg       <= `SMID_MASK_RST;
      level_reg      <= 32'h0000_0000;
      soft_reg       <= 1'b0;
      rom_base_reg   <= `SMID_ROM_BASE_RST;
      flash_base_reg <= `SMID_FLASH_BASE_RST;
      ram_base_reg   <= `SMID_RAM_BASE_RST;
      rom_size_reg   <= `SMID_SIZE_RST;
      flash_size_reg <= `SMID_SIZE_RST;
      ram_size_reg   <= `SMID_SIZE_RST;
      priv_reg       <= `SMID_PRIV_RST;
      fault_mode_reg <= 1'b0;
      write_reg      <= 1'b0;
      addr_reg       <= 32'h0000_0000;
      O_RDATA        <= 32'h0000_0000;
      O_DONE         <= 1'b0;
      O_ROM_SEL      <= 1'b0;
      O_FLASH_SEL    <= 1'b0;
      O_RAM_SEL      <= 1'b0;
      O_PERIPH_SEL   <= 8'h00;
      O_FAULT        <= 1'b0;
      O_SYS_RESET    <= 1'b0;
    end else begin
      O_DONE      <= 1'b0;
      O_FAULT     <= 1'b0;
      O_SYS_RESET <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (I_REQ) begin
            write_reg <= I_WRITE;
            addr_reg  <= cfg_off;
            if (illegal) begin
              O_DONE <= 1'b1;
              O_RDATA <= 32'h0000_0000;
              if (fault_mode_reg) begin
                O_SYS_RESET <= 1'b1;
              end else begin
                O_FAULT <= 1'b1;
              end
            end else if (hit_cfg) begin
              wait_cnt_reg <= `SMID_CFG_WAIT;
              state_reg    <= ST_WAIT;
              // writes only land in privileged mode
              if (I_WRITE && I_PRIV) begin
                if (cfg_off[7:0] == `SMID_CFG_MASK_LO) begin
                  mask_reg <= I_WDATA;
                end else if (cfg_off[7:0] == `SMID_CFG_LEVEL) begin
                  level_reg <= I_WDATA;
                end else if (cfg_off[7:0] == `SMID_CFG_SOFT) begin
                  soft_reg <= I_WDATA[0];
                end else if (cfg_off[7:0] == `SMID_CFG_SEL_BASE) begin
                  rom_base_reg <= I_WDATA;
                end else if (cfg_off[7:0] == `SMID_CFG_SEL_BASE + 32'h4) begin
                  flash_base_reg <= I_WDATA;
                end else if (cfg_off[7:0] == `SMID_CFG_SEL_BASE + 32'h8) begin
                  ram_base_reg <= I_WDATA;
                end else if (cfg_off[7:0] == `SMID_CFG_SEL_SIZE) begin
                  rom_size_reg <= clamp_size(I_WDATA[4:0]);
                end else if (cfg_off[7:0] == `SMID_CFG_SEL_SIZE + 32'h4) begin
                  flash_size_reg <= clamp_size(I_WDATA[4:0]);
                end else if (cfg_off[7:0] == `SMID_CFG_SEL_SIZE + 32'h8) begin
                  ram_size_reg <= clamp_size(I_WDATA[4:0]);
                end else if (cfg_off[7:0] == `SMID_CFG_PRIV) begin
                  priv_reg <= I_WDATA[10:0];
                end else if (cfg_off[7:0] == `SMID_CFG_FAULTMODE) begin
                  fault_mode_reg <= I_WDATA[0];
                end
              end
            end else if (hit_periph) begin
              O_PERIPH_SEL <= 8'h01 << periph_off[12:10];
              state_reg    <= ST_PERIF;
            end else begin
              O_ROM_SEL   <= hit_rom;
              O_FLASH_SEL <= !hit_rom && hit_flash;
              O_RAM_SEL   <= !hit_rom && !hit_flash && hit_ram;
              state_reg   <= ST_MEM;
            end
          end
        end
        ST_WAIT: begin
          if (wait_cnt_reg == 2'h1) begin
            O_DONE    <= 1'b1;
            O_RDATA   <= write_reg ? 32'h0000_0000 : cfg_rdata;
            state_reg <= ST_IDLE;
          end
          wait_cnt_reg <= wait_cnt_reg - 2'h1;
        end
        ST_PERIF: begin
          // hold the select until the peripheral finishes
          if (I_PERIPH_READY) begin
            O_DONE       <= 1'b1;
            O_RDATA      <= write_reg ? 32'h0000_0000 : I_PERIPH_RDATA;
            O_PERIPH_SEL <= 8'h00;
            state_reg    <= ST_IDLE;
          end
        end
        default: begin
          O_DONE      <= 1'b1;
          O_RDATA     <= write_reg ? 32'h0000_0000 : I_MEM_RDATA;
          O_ROM_SEL   <= 1'b0;
          O_FLASH_SEL <= 1'b0;
          O_RAM_SEL   <= 1'b0;
          state_reg   <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt level outputs, registered
  always @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_FAST_INTERRUPT_LEVEL   <= 1'b0;
      O_NORMAL_INTERRUPT_LEVEL <= 1'b0;
    end else begin
      O_FAST_INTERRUPT_LEVEL   <= |fast_req;
      O_NORMAL_INTERRUPT_LEVEL <= |norm_req;
    end
  end

endmodule

// ==== sim/smid_far_model.sv ====
// Purpose: far-side model answering memory and peripheral selects
// Assumes: one clock, synchronous active-low reset
// Notes:   data is junk outside a valid answer, so stale values never match
`timescale 1ns/1ns
module smid_far_model (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_nrst,
  // selects from the block, stretch length from the bench
  input  wire [7:0]  i_periph_sel,
  input  wire        i_mem_sel,
  input  wire [3:0]  i_delay,
  // answers to the block
  output wire        o_ready,
  output wire [31:0] o_periph_rdata,
  output wire [31:0] o_mem_rdata
);
  reg [3:0]  wait_reg;
  reg [31:0] junk_reg;
  ////////////////////////////////////////////////////////////////////////////
  // stretch counter runs while selected; junk pattern changes every cycle
  always @(posedge i_clk) begin
    if (!i_nrst || i_periph_sel == 8'h00)
      wait_reg <= 4'h0;
    else
      wait_reg <= wait_reg + 4'h1;
    junk_reg <= i_nrst ? junk_reg + 32'h1357_9BDF : 32'h5A5A_5A5A;
  end
  // ready after the requested number of stretch cycles
  assign o_ready        = |i_periph_sel && wait_reg == i_delay;
  assign o_periph_rdata = o_ready ? {24'hBEEF_00, i_periph_sel} : junk_reg;
  assign o_mem_rdata    = i_mem_sel ? 32'h1234_5678 : junk_reg;
endmodule

// ==== sim/smid_top_properties.sv ====
// Purpose: bus, select, fault and interrupt-level properties
// Assumes: one clock, synchronous active-low reset, one access at a time
// Notes:   sees only top-level ports; bound at the foot of this file
`timescale 1ns/1ns
`include "smid_consts.vh"
module smid_props (
  // clock and reset
  input wire        I_CLK,
  input wire        I_NRST,
  // processor bus
  input wire        I_REQ,
  input wire        I_WRITE,
  input wire        I_PRIV,
  input wire [31:0] I_ADDR,
  input wire        O_DONE,
  // selects and protection
  input wire        O_ROM_SEL,
  input wire        O_FLASH_SEL,
  input wire        O_RAM_SEL,
  input wire [7:0]  O_PERIPH_SEL,
  input wire        I_PERIPH_READY,
  input wire        O_FAULT,
  input wire        O_SYS_RESET,
  // interrupt levels
  input wire        O_FAST_INTERRUPT_LEVEL,
  input wire        O_NORMAL_INTERRUPT_LEVEL
);
  wire cfg_hit = (I_ADDR & ~32'h0000_00FF) == `SMID_CFG_BASE;
  wire mem_sel = O_ROM_SEL | O_FLASH_SEL | O_RAM_SEL;
  reg  wrote_reg;
  ////////////////////////////////////////////////////////////////////////////
  // remembers a privileged register write; before it all masks are off
  always @(posedge I_CLK) begin
    if (!I_NRST)
      wrote_reg <= 1'b0;
    else if (I_REQ && I_WRITE && I_PRIV && cfg_hit)
      wrote_reg <= 1'b1;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  ////////////////////////////////////////////////////////////////////////////
  a_cfg_wait: assert property (I_REQ && cfg_hit |=>
    !O_DONE ##1 O_DONE) else $error("register answer not after wait state");
  a_done_pulse: assert property (O_DONE |=> !O_DONE)
    else $error("done longer than one cycle");
  a_mem_sel: assert property (mem_sel |=> O_DONE && !mem_sel)
    else $error("memory select not one cycle before done");
  a_mem_onehot: assert property ($onehot0({O_ROM_SEL, O_FLASH_SEL,
    O_RAM_SEL})) else $error("several memory selects");
  a_periph_onehot: assert property ($onehot0(O_PERIPH_SEL))
    else $error("several peripheral selects");
  a_periph_hold: assert property (|O_PERIPH_SEL && !I_PERIPH_READY
    |=> $stable(O_PERIPH_SEL) && !O_DONE) else $error("stretch broken");
  a_periph_end: assert property (|O_PERIPH_SEL && I_PERIPH_READY
    |=> O_DONE && O_PERIPH_SEL == 8'h00) else $error("peripheral end");
  a_fault_done: assert property (O_FAULT || O_SYS_RESET |-> O_DONE
    && !(O_FAULT && O_SYS_RESET) && O_PERIPH_SEL == 8'h00 && !mem_sel)
    else $error("fault without done or with select");
  a_mask_blocks: assert property (!wrote_reg |->
    !O_FAST_INTERRUPT_LEVEL && !O_NORMAL_INTERRUPT_LEVEL)
    else $error("interrupt level while all masked");
  c_fault: cover property (O_FAULT);
  c_reset: cover property (O_SYS_RESET);
  c_stretch: cover property (|O_PERIPH_SEL && !I_PERIPH_READY);
  c_fast: cover property (O_FAST_INTERRUPT_LEVEL);
endmodule
bind smid_top smid_props u_props (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_REQ(I_REQ), .I_WRITE(I_WRITE),
  .I_PRIV(I_PRIV), .I_ADDR(I_ADDR), .O_DONE(O_DONE),
  .O_ROM_SEL(O_ROM_SEL), .O_FLASH_SEL(O_FLASH_SEL), .O_RAM_SEL(O_RAM_SEL),
  .O_PERIPH_SEL(O_PERIPH_SEL), .I_PERIPH_READY(I_PERIPH_READY),
  .O_FAULT(O_FAULT), .O_SYS_RESET(O_SYS_RESET),
  .O_FAST_INTERRUPT_LEVEL(O_FAST_INTERRUPT_LEVEL),
  .O_NORMAL_INTERRUPT_LEVEL(O_NORMAL_INTERRUPT_LEVEL));

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the system module
// Assumes: 100 MHz clock, reset low for 4 cycles, one access at a time
// Notes:   access task numbers negedges from the request-raising edge
`timescale 1ns/1ns
`include "smid_consts.vh"
module tb;
  localparam [31:0] CB = `SMID_CFG_BASE;
  localparam [31:0] PB = `SMID_PERIPH_BASE;
  reg         clk, nrst, req, wr, pv;
  reg  [31:0] addr, wdata, g_rd;
  reg  [30:0] src;
  reg  [3:0]  dly;
  reg  [10:0] g_sv;
  reg  [1:0]  g_fl;
  wire [31:0] rdata, p_rdata, m_rdata;
  wire [7:0]  psel;
  wire        done, rom, fl, ram, rdy, flt, srst, fst, nrm;
  integer     fails, total_checks, cyc, nd, g_ns, i;
  smid_top dut (
    .I_CLK(clk), .I_NRST(nrst), .I_REQ(req), .I_WRITE(wr), .I_PRIV(pv),
    .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_DONE(done),
    .O_ROM_SEL(rom), .O_FLASH_SEL(fl), .O_RAM_SEL(ram),
    .O_PERIPH_SEL(psel), .I_PERIPH_READY(rdy),
    .I_PERIPH_RDATA(p_rdata), .I_MEM_RDATA(m_rdata),
    .O_FAULT(flt), .O_SYS_RESET(srst),
    .I_BROWNOUT_REQUEST(src[0]), .I_EXTERNAL_PIN_REQUEST(src[1]),
    .I_WATCHDOG_EXPIRY_REQUEST(src[2]), .I_WATCHDOG_HALF_REQUEST(src[3]),
    .I_SERIAL_ERROR_REQUEST(src[4]), .I_SERIAL0_RECEIVE_REQUEST(src[5]),
    .I_SERIAL0_TRANSMIT_REQUEST(src[6]), .I_SERIAL1_RECEIVE_REQUEST(src[7]),
    .I_SERIAL1_TRANSMIT_REQUEST(src[8]), .I_PMBUS_REQUEST(src[9]),
    .I_COMPARATOR_SERIAL_REQUEST(src[10]),
    .I_FRONT_END_ZERO_REQUEST(src[11]), .I_UPPER_REQUEST(src[30:12]),
    .O_FAST_INTERRUPT_LEVEL(fst), .O_NORMAL_INTERRUPT_LEVEL(nrm));
  smid_far_model far (
    .i_clk(clk), .i_nrst(nrst), .i_periph_sel(psel),
    .i_mem_sel(rom | fl | ram), .i_delay(dly), .o_ready(rdy),
    .o_periph_rdata(p_rdata), .o_mem_rdata(m_rdata));
  ////////////////////////////////////////////////////////////////////////////
  // one bus access: request pulse, then watch selects and done
  task acc(input w, input p, input [31:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      req   <= 1'b1;
      wr    <= w;
      pv    <= p;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      req  <= 1'b0;
      nd   = 0;
      g_ns = 0;
      g_sv = 11'h000;
      // n = 1 was the request cycle; 2 is the first after the taking edge
      for (n = 2; n < 40 && nd == 0; n = n + 1) begin
        @(negedge clk);
        if (g_ns == 0 && {psel, ram, fl, rom} !== 11'h000) begin
          g_ns = n;
          g_sv = {psel, ram, fl, rom};
        end
        if (done === 1'b1) begin
          nd   = n;
          g_rd = rdata;
          g_fl = {srst, flt};
        end
      end
    end
  endtask
  // compares one value and counts it
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset map, register answer timing and privileged writes
  task t_regs;
    begin
      chk({psel, ram, fl, rom, done, flt, srst, fst, nrm}, 32'h0);
      acc(1'b0, 1'b1, CB + 32'h24, 32'h0);
      chk(g_rd, `SMID_FLASH_BASE_RST);
      chk(nd, 3);
      acc(1'b0, 1'b1, CB + 32'h28, 32'h0);
      chk(g_rd, `SMID_RAM_BASE_RST);
      acc(1'b1, 1'b0, CB, 32'hFFFF_FFFF);
      acc(1'b0, 1'b1, CB, 32'h0);
      chk(g_rd, 32'h0);
      acc(1'b1, 1'b1, CB, 32'hFFFF_FFFF);
      acc(1'b0, 1'b1, CB, 32'h0);
      chk(g_rd, 32'hFFFF_FFFF);
      chk({fst, nrm}, 32'h1);
      $display("test regs done");
    end
  endtask
  // channels 0-30 alone, stacking, soft channel, routing, mask, clear
  task t_irq;
    begin
      for (i = 0; i < 31; i = i + 1) begin
        @(posedge clk);
        src <= 31'h1 << i;
        acc(1'b0, 1'b1, CB + 32'h14, 32'h0);
        chk(g_rd, i);
        acc(1'b0, 1'b1, CB + 32'h18, 32'h0);
        chk(g_rd, 32'h1 << i);
        chk({fst, nrm}, 32'h1);
      end
      @(posedge clk);
      src <= 31'h7FFF_FFFF;
      acc(1'b0, 1'b1, CB + 32'h14, 32'h0);
      chk(g_rd, 30);
      acc(1'b1, 1'b1, CB + 32'h0C, 32'h1);
      acc(1'b0, 1'b1, CB + 32'h14, 32'h0);
      chk(g_rd, 31);
      acc(1'b1, 1'b1, CB + 32'h0C, 32'h0);
      @(posedge clk);
      src <= 31'h0000_0220;
      acc(1'b1, 1'b1, CB + 32'h08, 32'h0000_0020);
      acc(1'b0, 1'b1, CB + 32'h10, 32'h0);
      chk(g_rd, 5);
      acc(1'b0, 1'b1, CB + 32'h14, 32'h0);
      chk(g_rd, 9);
      chk({fst, nrm}, 32'h3);
      acc(1'b1, 1'b1, CB, 32'h0);
      acc(1'b0, 1'b1, CB + 32'h18, 32'h0);
      chk(g_rd, 32'h0000_0220);
      chk({fst, nrm}, 32'h0);
      acc(1'b1, 1'b1, CB, 32'hFFFF_FFFF);
      chk({fst, nrm}, 32'h3);
      @(posedge clk);
      src <= 31'h0;
      acc(1'b0, 1'b1, CB + 32'h14, 32'h0);
      chk(g_rd, 32);
      chk({fst, nrm}, 32'h0);
      $display("test irq done");
    end
  endtask
  // memory selects at window edges, resizing, unmapped holes
  task t_mem;
    reg [31:0] at [0:3];
    reg [31:0] ex [0:3];
    begin
      at[0] = 32'h0;
      at[1] = 32'h7FFC;
      at[2] = `SMID_FLASH_BASE_RST;
      at[3] = `SMID_RAM_BASE_RST;
      ex[0] = 32'h1;
      ex[1] = 32'h1;
      ex[2] = 32'h2;
      ex[3] = 32'h4;
      for (i = 0; i < 4; i = i + 1) begin
        acc(1'b0, 1'b1, at[i], 32'h0);
        chk(g_sv, ex[i]);
        chk(g_ns, 2);
        chk(nd, 3);
        chk(g_rd, 32'h1234_5678);
      end
      acc(1'b0, 1'b1, 32'h8000, 32'h0);
      chk({g_sv, g_fl, nd[3:0]}, 32'h12);
      acc(1'b1, 1'b1, CB + 32'h30, 32'h10);
      acc(1'b0, 1'b1, 32'h8000, 32'h0);
      chk(g_sv, 32'h1);
      acc(1'b1, 1'b1, CB + 32'h30, 32'h9);
      acc(1'b0, 1'b1, CB + 32'h30, 32'h0);
      chk(g_rd, 32'hA);
      acc(1'b0, 1'b1, 32'h400, 32'h0);
      chk({g_sv, g_fl, nd[3:0]}, 32'h12);
      acc(1'b1, 1'b1, CB + 32'h30, 32'hF);
      $display("test mem done");
    end
  endtask
  // each peripheral window with a longer stretch, then protection
  task t_periph;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge clk);
        dly <= i[3:0];
        acc(1'b0, 1'b1, PB + i * 1024, 32'h0);
        chk(g_sv, 32'h8 << i);
        chk(nd, 3 + i);
        chk(g_rd, 32'hBEEF_0000 | (32'h1 << i));
      end
      @(posedge clk);
      dly <= 4'h0;
      acc(1'b0, 1'b1, PB + 8 * 1024, 32'h0);
      chk({g_sv, g_fl}, 32'h1);
      acc(1'b1, 1'b1, CB + 32'h40, 32'h8);
      acc(1'b0, 1'b0, PB, 32'h0);
      chk({g_sv, g_fl, nd[3:0]}, 32'h12);
      acc(1'b1, 1'b1, CB + 32'h44, 32'h1);
      acc(1'b0, 1'b0, PB, 32'h0);
      chk({g_sv, g_fl, nd[3:0]}, 32'h22);
      acc(1'b0, 1'b1, PB, 32'h0);
      chk({g_sv, g_fl}, 32'h20);
      $display("test periph done");
    end
  endtask
  // prints the counts and the verdict, then stops
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock generator and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  // main sequence
  initial begin
    {nrst, req, wr, pv, addr, wdata, src, dly} = 0;
    {fails, total_checks, cyc} = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    src  <= 31'h7FFF_FFFF; // all sources raised while every mask is off
    @(negedge clk);
    t_regs;
    t_irq;
    t_mem;
    t_periph;
    end_sim;
  end
endmodule
